// File: rtl/cfgport_pkg.sv
// Purpose: Shared constants and types of the configuration port register bank
// Assumes: One 25 MHz clock, 32-bit register words
// Notes: Offsets are relative to the build-time base location
package cfgport_pkg;
    localparam int DATA_W = 32;
    localparam logic [31:0] OFF_GATE = 32'h0000_001c;
    localparam logic [31:0] OFF_FLAGS = 32'h0000_0020;
    localparam logic [31:0] OFF_EN = 32'h0000_0028;
    localparam logic [31:0] OFF_WKEY = 32'h0000_0100;
    localparam logic [31:0] OFF_RKEY = 32'h0000_0104;
    localparam logic [31:0] OFF_SIZE = 32'h0000_0108;
    localparam logic [31:0] OFF_CTRL = 32'h0000_010c;
    localparam logic [31:0] OFF_STATE = 32'h0000_0110;
    localparam logic [31:0] OFF_FREE = 32'h0000_0114;
    localparam logic [31:0] OFF_FILL = 32'h0000_0118;
    localparam logic [31:0] OFF_ABORT = 32'h0000_011c;
    localparam int GATE_BIT = 31;
    localparam int NUM_FLAGS = 4;
    localparam int FLAG_OUT_BELOW = 0;
    localparam int FLAG_IN_ABOVE = 1;
    localparam int FLAG_OUT_EMPTY = 2;
    localparam int FLAG_IN_FULL = 3;
    localparam int CTRL_W = 5;
    localparam int CTRL_WRITE = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_CLEAR = 2;
    localparam int CTRL_SWRST = 3;
    localparam int CTRL_ABORT = 4;
    localparam int STATE_DONE = 0;
    localparam int SIZE_W = 12;
    localparam int OUT_DEPTH = 1024;
    localparam int IN_DEPTH = 256;
    localparam int OUT_LVL_W = 11;
    localparam int IN_LVL_W = 9;
    localparam logic [OUT_LVL_W-1:0] OUT_USABLE = 11'h3ff;
    localparam logic [OUT_LVL_W-1:0] OUT_HALF = 11'h200;
    localparam logic [IN_LVL_W-1:0] IN_USABLE = 9'h0ff;
    localparam logic [IN_LVL_W-1:0] IN_HALF = 9'h080;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ENG_IDLE, ENG_SEND, ENG_READBACK} engine_state_t;
endpackage

// File: rtl/stream_if.sv
// Purpose: Valid/ready word stream between internal modules
// Assumes: Word taken on a clock edge where valid and ready are both high
// Notes: None
`timescale 1ns/10ps
interface stream_if #(parameter int W = 32) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport dst(input valid, input data, output ready);
endinterface

// File: rtl/word_fifo.sv
// Purpose: Synchronous word FIFO holding one less word than its array depth
// Assumes: DEPTH is a power of two
// Notes: Clear empties the FIFO in one cycle
`timescale 1ns/10ps
module word_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 1024
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clear,
    stream_if.dst push_side,
    stream_if.src pop_side,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] level_reg, level_next;
    logic do_push, do_pop;

    assign push_side.ready = level_reg < (AW+1)'(DEPTH - 1);
    assign pop_side.valid = level_reg != '0;
    assign pop_side.data = mem[rd_ptr_reg];
    assign do_push = push_side.valid && push_side.ready;
    assign do_pop = pop_side.valid && pop_side.ready;
    assign level = level_reg;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        level_next = level_reg;
        if (clear) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            level_next = '0;
        end else begin
            if (do_push) begin
                wr_ptr_next = wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_next = rd_ptr_reg + 1'b1;
            end
            level_next = level_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_side.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            level_reg <= level_next;
        end
    end
endmodule

// File: rtl/two_slot_buffer.sv
// Purpose: Two-entry buffer so a stalled receiver loses no word
// Assumes: Same clock on both sides
// Notes: Ready toward the source is registered state only
`timescale 1ns/10ps
module two_slot_buffer #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clear,
    stream_if.dst in_side,
    stream_if.src out_side
);
    logic [W-1:0] slot0_reg, slot0_next, slot1_reg, slot1_next;
    logic full0_reg, full0_next, full1_reg, full1_next;
    logic take, give;

    assign in_side.ready = !full1_reg;
    assign out_side.valid = full0_reg;
    assign out_side.data = slot0_reg;
    assign take = in_side.valid && !full1_reg;
    assign give = full0_reg && out_side.ready;

    always_comb begin
        slot0_next = slot0_reg;
        slot1_next = slot1_reg;
        full0_next = full0_reg;
        full1_next = full1_reg;
        if (clear) begin
            full0_next = 1'b0;
            full1_next = 1'b0;
        end else if (give) begin
            if (full1_reg) begin
                slot0_next = slot1_reg;
                full1_next = 1'b0;
            end else if (take) begin
                slot0_next = in_side.data;
            end else begin
                full0_next = 1'b0;
            end
        end else if (take) begin
            if (!full0_reg) begin
                slot0_next = in_side.data;
                full0_next = 1'b1;
            end else begin
                slot1_next = in_side.data;
                full1_next = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            slot0_reg <= '0;
            slot1_reg <= '0;
            full0_reg <= 1'b0;
            full1_reg <= 1'b0;
        end else begin
            slot0_reg <= slot0_next;
            slot1_reg <= slot1_next;
            full0_reg <= full0_next;
            full1_reg <= full1_next;
        end
    end
endmodule

// File: rtl/config_port_host_registers.sv
// Purpose: AXI4-Lite register bank, FIFOs and transfer engine of a config port host
// Assumes: Config port runs on core_clk; bus master keeps the write valids together
// Notes: Control bits 2 to 4 act for one cycle and then clear themselves
//
// Contract
// - Registers decode at fixed offsets added to the build-time base location.
// - Writes take the whole 32-bit data word; byte strobes are ignored.
// - Gate bit 31 passes or blocks the interrupt output; resets to zero.
// - Four interrupt sources, each in its own flag bit at 020h.
// - Writing 1 to a flag bit inverts it; 0 leaves it; reads show it.
// - All flag bits are zero after reset; bits 0 and 2 set on the first clock after, the outbound FIFO being empty.
// - Flag 1 sets and stays while inbound FIFO exceeds half depth.
// - Flag 0 sets and stays while outbound FIFO is below half depth.
// - Enable register at 028h has one enable per flag, reset zero.
// - Enable bit 1 permits its source, 0 suppresses it.
// - Each write to 100h pushes the word into the outbound FIFO.
// - Each read of 104h returns the next inbound FIFO word.
// - Write-only 12-bit field at 108h sets readback word count, resets zero.
// - Outbound FIFO holds depth minus one; 114h reports that free space.
// - Control at 10Ch read/write; 110h to 11Ch read only; 110h reads 1 and 114h 3FFh at reset, others zero.
// - Control bit 0 starts sending, control bit 1 starts readback.
`timescale 1ns/10ps
module config_port_host_registers #(
    parameter logic [31:0] base_location_param = 32'h0000_0000
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [cfgport_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [cfgport_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic interrupt_output,
    output logic [cfgport_pkg::DATA_W-1:0] cfg_wr_data,
    output logic cfg_wr_valid,
    input wire logic cfg_wr_ready,
    output logic cfg_rd_req,
    input wire logic [cfgport_pkg::DATA_W-1:0] cfg_rd_data,
    input wire logic cfg_rd_valid,
    output logic cfg_abort,
    input wire logic [cfgport_pkg::DATA_W-1:0] abort_status_word,
    input wire logic abort_status_valid
);
    import cfgport_pkg::*;

    // ------------------------------------------------------------
    // Storage and paths
    // ------------------------------------------------------------
    stream_if #(.W(DATA_W)) w_in ();
    stream_if #(.W(DATA_W)) w_out ();
    stream_if #(.W(DATA_W)) s_in ();
    stream_if #(.W(DATA_W)) s_out ();
    stream_if #(.W(DATA_W)) r_in ();
    stream_if #(.W(DATA_W)) r_out ();

    logic global_irq_gate_bit_reg, global_irq_gate_bit_next;
    logic [NUM_FLAGS-1:0] interrupt_flags_reg, interrupt_flags_next;
    logic [NUM_FLAGS-1:0] interrupt_source_enables_reg, interrupt_source_enables_next;
    logic [SIZE_W-1:0] readback_word_count_reg, readback_word_count_next;
    logic [CTRL_W-1:0] transfer_control_reg, transfer_control_next;
    logic [DATA_W-1:0] abort_capture_reg, abort_capture_next;
    engine_state_t state_reg, state_next;
    logic [SIZE_W-1:0] remain_reg, remain_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [NUM_FLAGS-1:0] toggle_mask, flag_cond;
    logic [OUT_LVL_W-1:0] out_level, outbound_free_slots;
    logic [IN_LVL_W-1:0] in_level;
    logic [31:0] woff, roff;
    logic aw_go, ar_go, is_wkey, swrst_now, abort_now, fifo_clear;

    word_fifo #(.W(DATA_W), .DEPTH(OUT_DEPTH)) outbound_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(fifo_clear),
        .push_side(w_in),
        .pop_side(w_out),
        .level(out_level)
    );

    two_slot_buffer #(.W(DATA_W)) send_buffer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(fifo_clear),
        .in_side(s_in),
        .out_side(s_out)
    );

    word_fifo #(.W(DATA_W), .DEPTH(IN_DEPTH)) inbound_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(fifo_clear),
        .push_side(r_in),
        .pop_side(r_out),
        .level(in_level)
    );

    // ------------------------------------------------------------
    // Combinational wiring
    // ------------------------------------------------------------
    assign woff = s_axi_awaddr - base_location_param;
    assign roff = s_axi_araddr - base_location_param;
    assign is_wkey = woff == OFF_WKEY;
    // Keyhole writes stall while the outbound FIFO has no room
    assign aw_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg && (!is_wkey || w_in.ready);
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign ar_go = s_axi_arvalid && !rvalid_reg;
    assign s_axi_arready = ar_go;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    assign w_in.valid = aw_go && is_wkey;
    assign w_in.data = s_axi_wdata;
    assign r_out.ready = ar_go && (roff == OFF_RKEY);

    assign s_in.valid = w_out.valid && (state_reg == ENG_SEND);
    assign s_in.data = w_out.data;
    assign w_out.ready = s_in.ready && (state_reg == ENG_SEND);
    assign cfg_wr_valid = s_out.valid;
    assign cfg_wr_data = s_out.data;
    assign s_out.ready = cfg_wr_ready;

    assign cfg_rd_req = (state_reg == ENG_READBACK) && (remain_reg != '0) && r_in.ready;
    assign r_in.valid = cfg_rd_valid && cfg_rd_req;
    assign r_in.data = cfg_rd_data;

    assign swrst_now = transfer_control_reg[CTRL_SWRST];
    assign abort_now = transfer_control_reg[CTRL_ABORT];
    assign fifo_clear = transfer_control_reg[CTRL_CLEAR] || swrst_now || abort_now;
    assign cfg_abort = abort_now;

    assign outbound_free_slots = OUT_USABLE - out_level;
    assign flag_cond[FLAG_OUT_BELOW] = out_level < OUT_HALF;
    assign flag_cond[FLAG_IN_ABOVE] = in_level > IN_HALF;
    assign flag_cond[FLAG_OUT_EMPTY] = out_level == '0;
    assign flag_cond[FLAG_IN_FULL] = in_level == IN_USABLE;
    assign interrupt_output = global_irq_gate_bit_reg
        && |(interrupt_flags_reg & interrupt_source_enables_reg);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        global_irq_gate_bit_next = global_irq_gate_bit_reg;
        interrupt_source_enables_next = interrupt_source_enables_reg;
        readback_word_count_next = readback_word_count_reg;
        transfer_control_next = transfer_control_reg;
        abort_capture_next = abort_capture_reg;
        state_next = state_reg;
        remain_next = remain_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        toggle_mask = '0;
        transfer_control_next[CTRL_CLEAR] = 1'b0;
        transfer_control_next[CTRL_SWRST] = 1'b0;
        transfer_control_next[CTRL_ABORT] = 1'b0;
        if (abort_status_valid) begin
            abort_capture_next = abort_status_word;
        end
        case (state_reg)
            ENG_IDLE: begin
                if (transfer_control_reg[CTRL_WRITE]) begin
                    state_next = ENG_SEND;
                end else if (transfer_control_reg[CTRL_READ]) begin
                    state_next = ENG_READBACK;
                    remain_next = readback_word_count_reg;
                end
            end
            ENG_SEND: begin
                if (!w_out.valid && !s_out.valid) begin
                    transfer_control_next[CTRL_WRITE] = 1'b0;
                    state_next = ENG_IDLE;
                end
            end
            ENG_READBACK: begin
                if (remain_reg == '0) begin
                    transfer_control_next[CTRL_READ] = 1'b0;
                    state_next = ENG_IDLE;
                end else if (r_in.valid) begin
                    remain_next = remain_reg - 1'b1;
                end
            end
            default: begin
                state_next = ENG_IDLE;
            end
        endcase
        if (abort_now) begin
            state_next = ENG_IDLE;
            transfer_control_next[CTRL_WRITE] = 1'b0;
            transfer_control_next[CTRL_READ] = 1'b0;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_go) begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (woff)
                OFF_GATE: global_irq_gate_bit_next = s_axi_wdata[GATE_BIT];
                OFF_FLAGS: toggle_mask = s_axi_wdata[NUM_FLAGS-1:0];
                OFF_EN: interrupt_source_enables_next = s_axi_wdata[NUM_FLAGS-1:0];
                OFF_SIZE: readback_word_count_next = s_axi_wdata[SIZE_W-1:0];
                OFF_CTRL: transfer_control_next = s_axi_wdata[CTRL_W-1:0];
                OFF_WKEY, OFF_RKEY, OFF_STATE, OFF_FREE, OFF_FILL, OFF_ABORT: begin
                end
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (ar_go) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            case (roff)
                OFF_GATE: rdata_next[GATE_BIT] = global_irq_gate_bit_reg;
                OFF_FLAGS: rdata_next[NUM_FLAGS-1:0] = interrupt_flags_reg;
                OFF_EN: rdata_next[NUM_FLAGS-1:0] = interrupt_source_enables_reg;
                OFF_RKEY: rdata_next = r_out.valid ? r_out.data : '0;
                OFF_CTRL: rdata_next[CTRL_W-1:0] = transfer_control_reg;
                OFF_STATE: rdata_next[STATE_DONE] = state_reg == ENG_IDLE;
                OFF_FREE: rdata_next[OUT_LVL_W-1:0] = outbound_free_slots;
                OFF_FILL: rdata_next[IN_LVL_W-2:0] = in_level[IN_LVL_W-2:0];
                OFF_ABORT: rdata_next = abort_capture_reg;
                OFF_WKEY, OFF_SIZE: begin
                end
                default: rresp_next = RESP_SLVERR;
            endcase
        end
        // A live condition wins over a toggle in the same cycle
        interrupt_flags_next = (interrupt_flags_reg ^ toggle_mask) | flag_cond;
        if (swrst_now) begin
            global_irq_gate_bit_next = 1'b0;
            interrupt_flags_next = '0;
            interrupt_source_enables_next = '0;
            readback_word_count_next = '0;
            transfer_control_next = '0;
            abort_capture_next = '0;
            state_next = ENG_IDLE;
            remain_next = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_gate_bit_reg <= 1'b0;
            interrupt_flags_reg <= '0;
            interrupt_source_enables_reg <= '0;
            readback_word_count_reg <= '0;
            transfer_control_reg <= '0;
            abort_capture_reg <= '0;
            state_reg <= ENG_IDLE;
            remain_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end else begin
            global_irq_gate_bit_reg <= global_irq_gate_bit_next;
            interrupt_flags_reg <= interrupt_flags_next;
            interrupt_source_enables_reg <= interrupt_source_enables_next;
            readback_word_count_reg <= readback_word_count_next;
            transfer_control_reg <= transfer_control_next;
            abort_capture_reg <= abort_capture_next;
            state_reg <= state_next;
            remain_reg <= remain_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_gate_blocks_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
        !global_irq_gate_bit_reg |-> !interrupt_output)
        else $error("interrupt high with gate off");
    chk_irq_equation: assert property (@(posedge core_clk) disable iff (!rst_b)
        (global_irq_gate_bit_reg && |(interrupt_flags_reg & interrupt_source_enables_reg))
        == interrupt_output)
        else $error("interrupt output disagrees with flags");
    chk_flag_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
        (aw_go && woff == OFF_FLAGS && !swrst_now)
        |=> (interrupt_flags_reg & ~$past(flag_cond))
        == (($past(interrupt_flags_reg) ^ $past(s_axi_wdata[NUM_FLAGS-1:0])) & ~$past(flag_cond)))
        else $error("flag toggle wrong");
    chk_above_half: assert property (@(posedge core_clk) disable iff (!rst_b)
        (in_level > IN_HALF && !swrst_now) |=> interrupt_flags_reg[FLAG_IN_ABOVE])
        else $error("above-half flag not set");
    chk_below_half: assert property (@(posedge core_clk) disable iff (!rst_b)
        (out_level < OUT_HALF && !swrst_now) |=> interrupt_flags_reg[FLAG_OUT_BELOW])
        else $error("below-half flag not set");
    chk_enable_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (aw_go && woff == OFF_EN && !swrst_now)
        |=> interrupt_source_enables_reg == $past(s_axi_wdata[3:0]))
        else $error("enable write lost");
    chk_size_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (aw_go && woff == OFF_SIZE && !swrst_now)
        |=> readback_word_count_reg == $past(s_axi_wdata[11:0]))
        else $error("size write lost");
    chk_keyhole_push: assert property (@(posedge core_clk) disable iff (!rst_b)
        (aw_go && is_wkey && !fifo_clear && !w_out.ready)
        |=> out_level == $past(out_level) + 11'h001)
        else $error("keyhole write not pushed");
    chk_keyhole_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ar_go && roff == OFF_RKEY && r_out.valid)
        |=> s_axi_rvalid && s_axi_rdata == $past(r_out.data))
        else $error("keyhole read wrong word");
    chk_free_slots: assert property (@(posedge core_clk) disable iff (!rst_b)
        outbound_free_slots + out_level == OUT_USABLE)
        else $error("free slot count wrong");
    chk_send_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        (aw_go && woff == OFF_CTRL && s_axi_wdata[4:0] == 5'h01 && state_reg == ENG_IDLE
        && !transfer_control_reg[CTRL_READ] && transfer_control_reg[4:2] == 3'h0)
        |-> ##2 state_reg == ENG_SEND)
        else $error("send did not start");
endmodule

// File: test/cfg_port_model.sv
// Purpose: Far side of the config port, taking sent words and giving readback words
// Assumes: Words move on core_clk when valid and ready are both high
// Notes: Ready and valid alternate so that the design sees stalls
`timescale 1ns/10ps
module cfg_port_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cfg_wr_valid,
    input wire logic [31:0] cfg_wr_data,
    output logic cfg_wr_ready,
    input wire logic cfg_rd_req,
    output logic [31:0] cfg_rd_data,
    output logic cfg_rd_valid,
    output logic [31:0] last_wr,
    output logic [7:0] n_wr
);
    logic [7:0] n_rd;
    logic [1:0] tick;
    assign cfg_wr_ready = tick[1];
    assign cfg_rd_valid = tick[0];
    // Word is scrambled while not valid
    assign cfg_rd_data = tick[0] ? {24'hc0de00, n_rd} : ~{24'hc0de00, n_rd};
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 2'h0;
            n_rd <= 8'h0;
            n_wr <= 8'h0;
            last_wr <= 32'h0;
        end else begin
            tick <= tick + 2'h1;
            n_rd <= n_rd + 8'(cfg_rd_req && cfg_rd_valid);
            n_wr <= n_wr + 8'(cfg_wr_valid && cfg_wr_ready);
            if (cfg_wr_valid && cfg_wr_ready)
                last_wr <= cfg_wr_data;
        end
    end
endmodule

// File: test/config_port_host_registers_tb.sv
// Purpose: Self-checking bench of the config port register bank
// Assumes: Bus inputs change on the falling edge
// Notes: Byte strobes stay zero throughout
`timescale 1ns/10ps
module config_port_host_registers_tb;
    import cfgport_pkg::*;
    localparam logic [31:0] B = 32'h0000_4000;
    typedef struct {logic [31:0] off, wd, exp;} row_t;
    logic core_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, abort_status_valid = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic interrupt_output, cfg_wr_valid, cfg_wr_ready, cfg_rd_req, cfg_rd_valid, cfg_abort;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [31:0] abort_status_word = 32'h0, s_axi_rdata, cfg_wr_data, cfg_rd_data, last_wr;
    logic [7:0] n_wr;
    int n_errors = 0, num_checks = 0, cyc = 0;
    row_t rows[10] = '{'{OFF_GATE, 32'hffff_ffff, 32'h8000_0000},
        '{OFF_GATE, 32'h7fff_ffff, 32'h0}, '{OFF_EN, 32'hffff_fffa, 32'ha},
        '{OFF_EN, 32'h5, 32'h5}, '{OFF_EN, 32'h0, 32'h0}, '{OFF_SIZE, 32'hfff, 32'h0},
        '{OFF_STATE, 32'h0, 32'h1}, '{OFF_FREE, 32'h0, 32'h3ff},
        '{OFF_FILL, 32'hffff_ffff, 32'h0}, '{OFF_ABORT, 32'hffff_ffff, 32'h0}};
    config_port_host_registers #(.base_location_param(B)) DUT (.*);
    cfg_port_model partner (.*);
    always #20 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] off, input logic [31:0] d, input logic [1:0] rsp);
        @(negedge core_clk);
        s_axi_awaddr = B + off;
        s_axi_wdata = d;
        s_axi_awvalid = 1;
        s_axi_wvalid = 1;
        do @(posedge core_clk); while (!s_axi_awready);
        @(negedge core_clk);
        s_axi_awvalid = 0;
        s_axi_wvalid = 0;
        chk($sformatf("wr %h", off), {29'h1, rsp}, {29'h0, s_axi_bvalid, s_axi_bresp});
    endtask
    task automatic rd(input logic [31:0] off, input logic [31:0] e, input logic [1:0] rsp);
        @(negedge core_clk);
        s_axi_araddr = B + off;
        s_axi_arvalid = 1;
        do @(posedge core_clk); while (!s_axi_arready);
        @(negedge core_clk);
        s_axi_arvalid = 0;
        chk($sformatf("rd %h", off), e, s_axi_rdata);
        chk("rresp", {29'h1, rsp}, {29'h0, s_axi_rvalid, s_axi_rresp});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        #120 rst_b = 1;
        @(negedge core_clk);
        foreach (rows[i]) begin
            wr(rows[i].off, rows[i].wd, RESP_OKAY);
            rd(rows[i].off, rows[i].exp, RESP_OKAY);
        end
        rd(OFF_FLAGS, 32'h5, RESP_OKAY);
        wr(OFF_FLAGS, 32'h9, RESP_OKAY);
        rd(OFF_FLAGS, 32'hd, RESP_OKAY);
        wr(OFF_EN, 32'h8, RESP_OKAY);
        wr(OFF_GATE, 32'h8000_0000, RESP_OKAY);
        chk("irq", 32'h1, {31'h0, interrupt_output});
        wr(OFF_GATE, 32'h0, RESP_OKAY);
        chk("irq", 32'h0, {31'h0, interrupt_output});
        wr(OFF_GATE, 32'h8000_0000, RESP_OKAY);
        wr(OFF_FLAGS, 32'h8, RESP_OKAY);
        chk("irq", 32'h0, {31'h0, interrupt_output});
        wr(32'h30, 32'h1, RESP_SLVERR);
        rd(32'h30, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 3; i++)
            wr(OFF_WKEY, 32'h1234_5670 + i, RESP_OKAY);
        rd(OFF_FREE, 32'h3fc, RESP_OKAY);
        wr(OFF_CTRL, 32'h1, RESP_OKAY);
        for (int k = 0; k < 200 && n_wr !== 8'h3; k++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        chk("last", 32'h1234_5672, last_wr);
        chk("count", 32'h3, {24'h0, n_wr});
        rd(OFF_STATE, 32'h1, RESP_OKAY);
        wr(OFF_SIZE, 32'hffff_f004, RESP_OKAY);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        repeat (2) @(negedge core_clk);
        for (int k = 0; k < 200 && cfg_rd_req !== 1'b0; k++) @(negedge core_clk);
        rd(OFF_FILL, 32'h4, RESP_OKAY);
        for (int i = 0; i < 4; i++)
            rd(OFF_RKEY, {24'hc0de00, 8'(i)}, RESP_OKAY);
        abort_status_word = 32'h1122_3344;
        abort_status_valid = 1;
        @(negedge core_clk);
        abort_status_valid = 0;
        rd(OFF_ABORT, 32'h1122_3344, RESP_OKAY);
        rst_b = 0;
        @(negedge core_clk);
        rst_b = 1;
        rd(OFF_GATE, 32'h0, RESP_OKAY);
        rd(OFF_ABORT, 32'h0, RESP_OKAY);
        wr(OFF_SIZE, 32'hff, RESP_OKAY);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        repeat (2) @(negedge core_clk);
        for (int k = 0; k < 600 && cfg_rd_req !== 1'b0; k++) @(negedge core_clk);
        rd(OFF_FILL, 32'hff, RESP_OKAY);
        rd(OFF_FLAGS, 32'hf, RESP_OKAY);
        wr(OFF_CTRL, 32'h14, RESP_OKAY);
        chk("abort", 32'h1, {31'h0, cfg_abort});
        rd(OFF_FILL, 32'h0, RESP_OKAY);
        wr(OFF_EN, 32'hf, RESP_OKAY);
        wr(OFF_CTRL, 32'h8, RESP_OKAY);
        rd(OFF_EN, 32'h0, RESP_OKAY);
        results();
    end
endmodule
